// ===== rtl/adc_seq_pkg.sv
// Purpose: shared constants and types for the converter sequencing host
// Assumes: 20 MHz clock, 50 ns period
// Notes: times are kept in ns, us or ms as printed; cycle counts derive from them
package adc_seq_pkg;

    localparam int CLK_NS = 50;

    // least time in ns rounded up to whole clock cycles, never below one
    function automatic int cyc_ceil(input int t_ns);
        int c;
        c = (t_ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // wake-up and reset timing
    localparam int T_STANDBY_PIN_CONV_US = 100;
    localparam int T_SD_RST_MS = 50;
    localparam int T_RST_HIGH_NS = 50;
    localparam int T_RST_CONV_US = 25;
    localparam int STANDBY_PIN_CONV_CYC = cyc_ceil(T_STANDBY_PIN_CONV_US * 1000);
    localparam int SD_RST_CYC = cyc_ceil(T_SD_RST_MS * 1000000);
    localparam int RST_HIGH_CYC = cyc_ceil(T_RST_HIGH_NS);
    localparam int RST_CONV_CYC = cyc_ceil(T_RST_CONV_US * 1000);

    // conversion spacing
    localparam int T_CYC_PAR_NS = 5000;
    localparam int T_CYC_SER2_NS = 7000;
    localparam int T_CYC_SER1_NS = 9700;
    localparam int T_ACQ_US = 1;
    localparam int T_BUSY_MAX_US = 311;
    localparam int CYC_PAR = cyc_ceil(T_CYC_PAR_NS);
    localparam int CYC_SER2 = cyc_ceil(T_CYC_SER2_NS);
    localparam int CYC_SER1 = cyc_ceil(T_CYC_SER1_NS);
    localparam int ACQ_CYC = cyc_ceil(T_ACQ_US * 1000);
    localparam int BUSY_MAX_CYC = cyc_ceil(T_BUSY_MAX_US * 1000);

    // strobe timing: low time covers the data path through two flops
    localparam int T_RD_LOW_NS = 150;
    localparam int RD_LOW_CYC = cyc_ceil(T_RD_LOW_NS);
    localparam int BUSY_SETTLE_CYC = 4;

    // widths and counts
    localparam int TMR_W = 20;
    localparam int CNT_W = 9;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int OS_W = 3;
    localparam int CHAN_W = 3;
    localparam logic [CHAN_W-1:0] LAST_CHAN = 3'h7;
    localparam logic [OS_W-1:0] OS_NONE = 3'h0;

    // spacing selector codes
    localparam logic [1:0] SP_PAR = 2'h0;
    localparam logic [1:0] SP_SER2 = 2'h1;
    localparam logic [1:0] SP_SER1 = 2'h2;

    typedef enum logic [8:0] {
        ST_OFF = 9'h001,
        ST_WAKE = 9'h002,
        ST_RST = 9'h004,
        ST_RSTW = 9'h008,
        ST_IDLE = 9'h010,
        ST_SETTLE = 9'h020,
        ST_BUSY = 9'h040,
        ST_READ = 9'h080,
        ST_GAP = 9'h100
    } state_t;

endpackage

// ===== rtl/delay_tmr_if.sv
// Purpose: carrier between the sequencer and its delay timer
// Assumes: one clock domain
// Notes: load is a one-cycle request; done is a level while the count is spent
`timescale 1ns/10ps
`default_nettype none
interface delay_tmr_if;
    logic load;
    logic [adc_seq_pkg::TMR_W-1:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ===== rtl/delay_tmr.sv
// Purpose: down-counting delay timer for wake-up and reset waits
// Assumes: a load of n gives done n cycles later
// Notes: done stays high until the next load
`timescale 1ns/10ps
`default_nettype none
module delay_tmr
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // request side
    delay_tmr_if.tmr t
);

    logic [TMR_W-1:0] cnt_q;

    // count down after a load, hold at zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (t.load) begin
            cnt_q <= t.count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign t.done = (cnt_q == '0);

endmodule // delay_tmr
`default_nettype wire

// ===== rtl/adc_seq_host.sv
// Purpose: host sequencer that wakes, starts and reads an 8-channel sampling converter
// Assumes: parallel or byte-wide reads after conversion, separate select and read strobes
// Notes: all pin inputs pass two flops; all outputs are registered
//
// Behaviour
// - after standby rises, wait 100 us before any conversion start edge.
// - if the standby wait is missed, discard the first result or reset.
// - from shutdown, wait 50 ms from standby rising to reset rising.
// - hold reset high at least 50 ns when leaving shutdown.
// - after reset falls, wait 25 us before any conversion start edge.
// - space conversions 5 us for parallel reads or two-line reads during conversion.
// - space conversions 7 us for two-line serial reads after conversion.
// - space conversions 9.7 us for one-line serial reads after conversion.
// - keep oversample select stable 20 ns either side of busy falling.
// - parallel reads: select falls before read strobe, rises after it.
// - byte reads keep the same select and read strobe ordering.
// - allow 1 us from busy falling to the conversion start edge.
// - both conversion starts rise within 500 us of each other.
`timescale 1ns/10ps
`default_nettype none
module adc_seq_host
    import adc_seq_pkg::*;
#(
    parameter int SD_WAIT_CYC = SD_RST_CYC,
    parameter int BUSY_TMO_CYC = BUSY_MAX_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // user commands
    input wire logic wake_req,
    input wire logic from_shutdown,
    input wire logic sleep_req,
    input wire logic conv_req,
    input wire logic [OS_W-1:0] os_ratio,
    input wire logic byte_mode,
    input wire logic [1:0] spacing_sel,
    // user results
    output logic ready_q,
    output logic [WORD_W-1:0] data_word_q,
    output logic [CHAN_W-1:0] data_chan_q,
    output logic data_first_q,
    output logic data_valid_q,
    output logic conv_err_q,
    // converter pins
    output logic standby_pin,
    output logic adc_reset_q,
    output logic conv_start_group_a,
    output logic conv_start_group_b,
    output logic [OS_W-1:0] oversample_select,
    output logic cs_n_q,
    output logic rd_n_q,
    input wire logic busy,
    input wire logic first_channel_flag,
    input wire logic [WORD_W-1:0] parallel_word_bus
);

    state_t state_q;
    delay_tmr_if tif ();
    logic [1:0] busy_sync_q;
    logic [1:0] first_sync_q;
    logic [WORD_W-1:0] bus_m_q;
    logic [WORD_W-1:0] bus_s_q;
    logic [CNT_W-1:0] cyc_cnt_q;
    logic [CNT_W-1:0] acq_cnt_q;
    logic [CNT_W-1:0] spacing_d;
    logic [TMR_W-1:0] tmo_cnt_q;
    logic [1:0] rd_cnt_q;
    logic [CHAN_W-1:0] chan_q;
    logic hi_byte_q;
    logic done_all_q;
    logic [BYTE_W-1:0] lo_byte_q;
    logic standby_q;
    logic conv_q;
    logic [OS_W-1:0] os_q;
    logic tmr_load_q;
    logic [TMR_W-1:0] tmr_count_q;

    delay_tmr u_tmr (
        .mclk(mclk),
        .arst_n(arst_n),
        .t(tif.tmr)
    );

    assign tif.load = tmr_load_q;
    assign tif.count = tmr_count_q;
    assign standby_pin = standby_q;
    assign conv_start_group_a = conv_q;
    assign conv_start_group_b = conv_q;
    assign oversample_select = os_q;

    // two-flop synchronisers on every pin input
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_sync_q <= '0;
            first_sync_q <= '0;
            bus_m_q <= '0;
            bus_s_q <= '0;
        end else begin
            busy_sync_q <= {busy_sync_q[0], busy};
            first_sync_q <= {first_sync_q[0], first_channel_flag};
            bus_m_q <= parallel_word_bus;
            bus_s_q <= bus_m_q;
        end
    end

    // least spacing between conversion starts for the chosen read style
    always_comb begin
        case (spacing_sel)
            SP_SER2: spacing_d = CNT_W'(CYC_SER2);
            SP_SER1: spacing_d = CNT_W'(CYC_SER1);
            default: spacing_d = CNT_W'(CYC_PAR);
        endcase
    end

    // cycles since the last start edge and since busy fell, saturating
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_cnt_q <= '1;
            acq_cnt_q <= '1;
        end else begin
            // restart only on an issued start, so a waiting request cannot hold it at zero
            if (conv_q) begin
                cyc_cnt_q <= '0;
            end else if (cyc_cnt_q != '1) begin
                cyc_cnt_q <= cyc_cnt_q + 1'b1;
            end
            if (busy_sync_q[1]) begin
                acq_cnt_q <= '0;
            end else if (acq_cnt_q != '1) begin
                acq_cnt_q <= acq_cnt_q + 1'b1;
            end
        end
    end

    // busy watchdog: flags a conversion that overruns the longest busy time
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tmo_cnt_q <= '0;
            conv_err_q <= 1'b0;
        end else if (state_q == ST_BUSY) begin
            tmo_cnt_q <= tmo_cnt_q + 1'b1;
            if (tmo_cnt_q == TMR_W'(BUSY_TMO_CYC)) begin
                conv_err_q <= 1'b1;
            end
        end else begin
            tmo_cnt_q <= '0;
            if (conv_req) begin
                conv_err_q <= 1'b0;
            end
        end
    end

    // main sequencer: wake-up, start, wait for busy, read eight words
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_OFF;
            standby_q <= 1'b0;
            adc_reset_q <= 1'b0;
            conv_q <= 1'b0;
            os_q <= OS_NONE;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            ready_q <= 1'b0;
            tmr_load_q <= 1'b0;
            tmr_count_q <= '0;
            rd_cnt_q <= '0;
            chan_q <= '0;
            hi_byte_q <= 1'b0;
            done_all_q <= 1'b0;
            lo_byte_q <= '0;
            data_word_q <= '0;
            data_chan_q <= '0;
            data_first_q <= 1'b0;
            data_valid_q <= 1'b0;
        end else begin
            tmr_load_q <= 1'b0;
            data_valid_q <= 1'b0;
            conv_q <= 1'b0;
            case (state_q)
                ST_OFF: begin
                    if (wake_req) begin
                        standby_q <= 1'b1;
                        tmr_load_q <= 1'b1;
                        state_q <= ST_WAKE;
                        tmr_count_q <= from_shutdown ? TMR_W'(SD_WAIT_CYC)
                                                     : TMR_W'(STANDBY_PIN_CONV_CYC);
                        adc_reset_q <= 1'b0;
                    end
                end
                ST_WAKE: begin
                    // the wait is always kept, so the first result is good
                    if (!tmr_load_q && tif.done) begin
                        if (from_shutdown) begin
                            adc_reset_q <= 1'b1;
                            tmr_load_q <= 1'b1;
                            tmr_count_q <= TMR_W'(RST_HIGH_CYC);
                            state_q <= ST_RST;
                        end else begin
                            ready_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_RST: begin
                    if (!tmr_load_q && tif.done) begin
                        adc_reset_q <= 1'b0;
                        tmr_load_q <= 1'b1;
                        tmr_count_q <= TMR_W'(RST_CONV_CYC);
                        state_q <= ST_RSTW;
                    end
                end
                ST_RSTW: begin
                    if (!tmr_load_q && tif.done) begin
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (sleep_req) begin
                        standby_q <= 1'b0;
                        ready_q <= 1'b0;
                        state_q <= ST_OFF;
                    end else if (conv_req && ready_q && cyc_cnt_q >= spacing_d
                                 && acq_cnt_q >= CNT_W'(ACQ_CYC) && !busy_sync_q[1]) begin
                        conv_q <= 1'b1;
                        // select changes only here, long after busy fell
                        os_q <= os_ratio;
                        ready_q <= 1'b0;
                        rd_cnt_q <= '0;
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // give the synchronised busy time to rise
                    rd_cnt_q <= rd_cnt_q + 1'b1;
                    if (rd_cnt_q == 2'(BUSY_SETTLE_CYC - 1)) begin
                        state_q <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (!busy_sync_q[1]) begin
                        // select falls a cycle ahead of the read strobe
                        cs_n_q <= 1'b0;
                        chan_q <= '0;
                        hi_byte_q <= 1'b0;
                        done_all_q <= 1'b0;
                        state_q <= ST_GAP;
                    end
                end
                ST_READ: begin
                    rd_cnt_q <= rd_cnt_q + 1'b1;
                    if (rd_cnt_q == 2'(RD_LOW_CYC - 1)) begin
                        rd_n_q <= 1'b1;
                        state_q <= ST_GAP;
                        if (byte_mode && !hi_byte_q) begin
                            lo_byte_q <= bus_s_q[BYTE_W-1:0];
                            hi_byte_q <= 1'b1;
                        end else begin
                            data_word_q <= byte_mode ? {bus_s_q[BYTE_W-1:0], lo_byte_q}
                                                     : bus_s_q;
                            data_chan_q <= chan_q;
                            data_first_q <= first_sync_q[1];
                            data_valid_q <= 1'b1;
                            hi_byte_q <= 1'b0;
                            chan_q <= chan_q + 1'b1;
                            done_all_q <= (chan_q == LAST_CHAN);
                        end
                    end
                end
                ST_GAP: begin
                    // strobe high one full cycle between reads
                    if (done_all_q) begin
                        // select rises after the read strobe
                        cs_n_q <= 1'b1;
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        rd_n_q <= 1'b0;
                        rd_cnt_q <= '0;
                        state_q <= ST_READ;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

endmodule // adc_seq_host
`default_nettype wire

// ===== dv/adc_seq_host_props.sv
// Purpose: pin timing checks for the converter host
// Assumes: one clock, asynchronous active-low reset
// Notes: counters saturate; figures are in mclk cycles
`timescale 1ns/10ps
`default_nettype none
module adc_seq_host_props
    import adc_seq_pkg::*;
#(
    parameter int SD_WAIT_CYC = SD_RST_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // watched signals
    input wire logic [1:0] spacing_sel,
    input wire logic standby_pin,
    input wire logic adc_reset_q,
    input wire logic conv_start_group_a,
    input wire logic conv_start_group_b,
    input wire logic [OS_W-1:0] oversample_select,
    input wire logic cs_n_q,
    input wire logic rd_n_q,
    input wire logic busy
);
    logic [TMR_W-1:0] standby_pin_q, rst_q, gap_q, acq_q;
    logic rst_seen_q;
    int gap_min;

    function automatic logic [TMR_W-1:0] inc(input logic [TMR_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // least start spacing for the selected read style
    always_comb begin
        gap_min = (spacing_sel == SP_SER2) ? CYC_SER2
                : (spacing_sel == SP_SER1) ? CYC_SER1 : CYC_PAR;
    end

    // cycles since standby rise, reset fall, last start and busy fall
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            standby_pin_q <= '0;
            rst_q <= '0;
            gap_q <= '1;
            acq_q <= '1;
            rst_seen_q <= 1'b0;
        end else begin
            standby_pin_q <= standby_pin ? inc(standby_pin_q) : '0;
            rst_q <= adc_reset_q ? '0 : inc(rst_q);
            gap_q <= conv_start_group_a ? '0 : inc(gap_q);
            acq_q <= busy ? '0 : inc(acq_q);
            rst_seen_q <= standby_pin & (rst_seen_q | adc_reset_q);
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_rd_pulse;
        !rd_n_q [*3] ##1 rd_n_q;
    endsequence
    sequence s_rst_pulse;
        adc_reset_q [*2];
    endsequence

    property p_standby_pin_wait;
        $rose(conv_start_group_a) && !rst_seen_q |-> standby_pin_q >= STANDBY_PIN_CONV_CYC;
    endproperty
    a_standby_pin_wait: assert property (p_standby_pin_wait)
        else $error("start too soon after standby rise");
    property p_sd_wait;
        $rose(adc_reset_q) |-> standby_pin_q >= SD_WAIT_CYC;
    endproperty
    a_sd_wait: assert property (p_sd_wait)
        else $error("reset too soon after standby rise");
    property p_rst_high;
        $rose(adc_reset_q) |-> s_rst_pulse;
    endproperty
    a_rst_high: assert property (p_rst_high)
        else $error("reset pulse too short");
    property p_rst_conv;
        $rose(conv_start_group_a) && rst_seen_q |-> rst_q >= RST_CONV_CYC;
    endproperty
    a_rst_conv: assert property (p_rst_conv)
        else $error("start too soon after reset fall");
    property p_spacing;
        $rose(conv_start_group_a) |-> gap_q + 1 >= $past(gap_min);
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("starts too close together");
    property p_os_hold;
        $fell(busy) |-> $stable(oversample_select) ##1 $stable(oversample_select);
    endproperty
    a_os_hold: assert property (p_os_hold)
        else $error("ratio moved around busy fall");
    property p_strobe_order;
        !rd_n_q |-> !cs_n_q && !$past(cs_n_q);
    endproperty
    a_strobe_order: assert property (p_strobe_order)
        else $error("read strobe outside select");
    property p_rd_low;
        $fell(rd_n_q) |-> s_rd_pulse;
    endproperty
    a_rd_low: assert property (p_rd_low)
        else $error("read strobe low time wrong");
    property p_acq;
        $rose(conv_start_group_a) |-> acq_q >= ACQ_CYC;
    endproperty
    a_acq: assert property (p_acq)
        else $error("acquisition time too short");
    property p_pair;
        $rose(conv_start_group_a) |-> $rose(conv_start_group_b);
    endproperty
    a_pair: assert property (p_pair)
        else $error("start inputs not together");
endmodule // adc_seq_host_props

bind adc_seq_host adc_seq_host_props #(.SD_WAIT_CYC(SD_WAIT_CYC)) u_props (
    .mclk(mclk), .arst_n(arst_n), .spacing_sel(spacing_sel), .standby_pin(standby_pin),
    .adc_reset_q(adc_reset_q), .conv_start_group_a(conv_start_group_a),
    .conv_start_group_b(conv_start_group_b), .oversample_select(oversample_select),
    .cs_n_q(cs_n_q), .rd_n_q(rd_n_q), .busy(busy)
);
`default_nettype wire

// ===== dv/adc_dev_model.sv
// Purpose: behavioural eight-channel sampling converter
// Assumes: start pins are registered pulses on mclk
// Notes: channel c reads base_word plus c times 16'h1111
`timescale 1ns/10ps
`default_nettype none
module adc_dev_model
    import adc_seq_pkg::*;
(
    // clock and pins from the host
    input wire logic mclk,
    input wire logic standby_pin,
    input wire logic adc_reset_q,
    input wire logic conv_start_group_a,
    input wire logic conv_start_group_b,
    input wire logic [OS_W-1:0] oversample_select,
    input wire logic cs_n_q,
    input wire logic rd_n_q,
    // bench controls
    input wire logic byte_mode,
    input wire logic [WORD_W-1:0] base_word,
    // pins to the host
    output logic busy,
    output logic first_channel_flag,
    output logic [WORD_W-1:0] parallel_word_bus
);
    // all eight channels stay active, so six or four channel times never occur
    int conv_len [8] = '{76, 172, 360, 740, 1500, 3030, 6090, 76};
    int left;
    logic [3:0] rd_idx;
    logic [CHAN_W-1:0] ch;
    logic start_d, rd_prev, last_flag;
    logic [WORD_W-1:0] word, last_bus;

    initial begin
        busy = 1'b0;
        left = 0;
        rd_idx = '0;
        start_d = 1'b0;
        rd_prev = 1'b1;
        last_bus = '0;
        last_flag = 1'b0;
    end

    // busy from start edge to results ready
    always @(posedge mclk) begin
        start_d <= conv_start_group_a & conv_start_group_b;
        rd_prev <= rd_n_q;
        last_bus <= parallel_word_bus;
        last_flag <= first_channel_flag;
        if (rd_n_q && !rd_prev && !cs_n_q)
            rd_idx <= rd_idx + 1'b1;
        if (adc_reset_q || !standby_pin) begin
            busy <= 1'b0;
            left <= 0;
        end else if (conv_start_group_a && conv_start_group_b && !start_d) begin
            busy <= 1'b1;
            left <= conv_len[oversample_select];
            rd_idx <= '0;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            busy <= 1'b0;
        end
    end

    // data while strobed, a toggling pattern once released
    assign ch = byte_mode ? rd_idx[3:1] : rd_idx[2:0];
    assign word = base_word + WORD_W'(ch) * 16'h1111;
    always_comb begin
        if (!cs_n_q && !rd_n_q)
            parallel_word_bus = byte_mode
                ? {~last_bus[15:8], rd_idx[0] ? word[15:8] : word[7:0]} : word;
        else
            parallel_word_bus = ~last_bus;
        first_channel_flag = cs_n_q ? ~last_flag : (ch == 3'h0);
    end
endmodule // adc_dev_model
`default_nettype wire

// ===== dv/adc_seq_host_tb.sv
// Purpose: self-checking bench for the converter host
// Assumes: device model on the pins, short shutdown wait
// Notes: random ratios, read styles, spacing and data from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module adc_seq_host_tb
    import adc_seq_pkg::*;
;
    logic mclk, arst_n, wake_req, from_shutdown, sleep_req, conv_req, byte_mode;
    logic [OS_W-1:0] os_ratio, oversample_select;
    logic [1:0] spacing_sel;
    logic ready_q, data_first_q, data_valid_q, conv_err_q, standby_pin, adc_reset_q;
    logic conv_start_group_a, conv_start_group_b, cs_n_q, rd_n_q, busy, first_channel_flag;
    logic [WORD_W-1:0] data_word_q, parallel_word_bus, base_word;
    logic [CHAN_W-1:0] data_chan_q;
    int fail_count, check_count, seed;

    adc_seq_host #(.SD_WAIT_CYC(50), .BUSY_TMO_CYC(200)) dut (
        .mclk(mclk), .arst_n(arst_n), .wake_req(wake_req), .from_shutdown(from_shutdown),
        .sleep_req(sleep_req), .conv_req(conv_req), .os_ratio(os_ratio),
        .byte_mode(byte_mode), .spacing_sel(spacing_sel), .ready_q(ready_q),
        .data_word_q(data_word_q), .data_chan_q(data_chan_q), .data_first_q(data_first_q),
        .data_valid_q(data_valid_q), .conv_err_q(conv_err_q), .standby_pin(standby_pin),
        .adc_reset_q(adc_reset_q), .conv_start_group_a(conv_start_group_a),
        .conv_start_group_b(conv_start_group_b), .oversample_select(oversample_select),
        .cs_n_q(cs_n_q), .rd_n_q(rd_n_q), .busy(busy),
        .first_channel_flag(first_channel_flag), .parallel_word_bus(parallel_word_bus));

    adc_dev_model u_dev (
        .mclk(mclk), .standby_pin(standby_pin), .adc_reset_q(adc_reset_q),
        .conv_start_group_a(conv_start_group_a), .conv_start_group_b(conv_start_group_b),
        .oversample_select(oversample_select), .cs_n_q(cs_n_q), .rd_n_q(rd_n_q),
        .byte_mode(byte_mode), .base_word(base_word), .busy(busy),
        .first_channel_flag(first_channel_flag), .parallel_word_bus(parallel_word_bus));

    // clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [WORD_W-1:0] exp_word(input logic [WORD_W-1:0] b, input int c);
        return b + WORD_W'(c) * 16'h1111;
    endfunction

    task automatic step();
        @(posedge mclk);
        #2;
    endtask

    task automatic check(input logic ok, input string what);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // wake up and count cycles until the host is ready
    task automatic wake(input logic sd);
        int t;
        int hi;
        t = 0;
        hi = 0;
        from_shutdown = sd;
        wake_req = 1'b1;
        step();
        wake_req = 1'b0;
        while (ready_q !== 1'b1 && t < 4000) begin
            step();
            t++;
            if (adc_reset_q === 1'b1)
                hi++;
        end
        check(standby_pin === 1'b1, "standby low after wake");
        check(t < 4000, "wake timed out");
        check(t >= (sd ? 50 + RST_CONV_CYC : STANDBY_PIN_CONV_CYC), "ready too early");
        check(sd ? hi >= RST_HIGH_CYC : hi == 0, "reset pulse wrong");
    endtask

    // one conversion with its eight reads
    task automatic convert(input logic [2:0] os, input logic bm, input logic [1:0] sp,
                           input logic ovr);
        int t;
        int k;
        t = 0;
        k = 0;
        os_ratio = os;
        byte_mode = bm;
        spacing_sel = sp;
        base_word = WORD_W'($random(seed));
        conv_req = 1'b1;
        while (conv_start_group_a !== 1'b1 && t < 1000) begin
            step();
            t++;
        end
        conv_req = 1'b0;
        check(conv_start_group_b === 1'b1 && oversample_select === os,
              "start pair or ratio");
        while (!ovr && k < 8 && t < 3000) begin
            step();
            t++;
            if (data_valid_q === 1'b1) begin
                check(data_word_q === exp_word(base_word, k), "data word");
                check(data_chan_q === CHAN_W'(k) && data_first_q === (k == 0),
                      "channel tag");
                k++;
            end
        end
        check(ovr || k == 8, "missing words");
        t = 0;
        while (ready_q !== 1'b1 && t < 8000) begin
            step();
            t++;
        end
        check(ready_q === 1'b1 && conv_err_q === ovr, "overrun flag");
    endtask

    // watchdog
    initial begin
        #(60000 * 50);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        seed = 67351;
        fail_count = 0;
        check_count = 0;
        {arst_n, wake_req, from_shutdown, sleep_req, conv_req, byte_mode} = '0;
        os_ratio = '0;
        spacing_sel = '0;
        base_word = '0;
        repeat (8) @(posedge mclk);
        #2;
        arst_n = 1'b1;
        check(ready_q === 1'b0 && standby_pin === 1'b0, "awake after reset");
        wake(1'b0);
        for (int i = 0; i < 4; i++)
            convert(3'h0, i[0], i[1:0], 1'b0);
        convert(3'h1, 1'b1, SP_SER1, 1'b0);
        convert(3'h2, 1'b0, SP_PAR, 1'b1);
        repeat (6) begin
            r = $random(seed);
            convert({2'h0, r[0]}, r[1], r[3:2], 1'b0);
        end
        sleep_req = 1'b1;
        step();
        sleep_req = 1'b0;
        repeat (3) step();
        check(standby_pin === 1'b0 && ready_q === 1'b0, "still awake after sleep");
        wake(1'b1);
        convert(3'h0, 1'b0, SP_PAR, 1'b0);
        give_verdict();
    end
endmodule // adc_seq_host_tb
`default_nettype wire
